/* File: rtl/shs_pkg.sv */
package shs_pkg;

    // ********************************************************************
    // Register indices; the byte address on the bus is four times the
    // index, so the two low address bits must be zero.
    // ********************************************************************
    localparam logic [15:0] SHS_IDX_STATUS = 16'h1802;
    localparam logic [15:0] SHS_IDX_ADDR0 = 16'h1804;
    localparam logic [15:0] SHS_IDX_ADDR1 = 16'h1806;
    localparam logic [15:0] SHS_IDX_RDMASK = 16'h1808;
    localparam logic [15:0] SHS_IDX_IRQMASK = 16'h1810;
    localparam int SHS_ADDR_W = 18;

    // ********************************************************************
    // Status bit positions.
    // ********************************************************************
    localparam int SHS_BIT_CMD_ERR = 7;
    localparam int SHS_BIT_DATA_ERR = 6;
    localparam int SHS_BIT_TIMEOUT = 5;
    localparam int SHS_BIT_RSVD = 4;
    localparam int SHS_BIT_CMD_IDLE = 3;
    localparam int SHS_BIT_READ_WAIT = 2;
    localparam int SHS_BIT_CARD_IRQ = 1;
    localparam int SHS_BIT_CTRL_IDLE = 0;

    // ********************************************************************
    // Reset values.
    // ********************************************************************
    localparam logic [7:0] SHS_RST_STATUS = 8'h00;
    localparam logic [15:0] SHS_RST_ADDR0 = 16'h0000;
    localparam logic [15:0] SHS_RST_ADDR1 = 16'h0001;
    localparam logic [15:0] SHS_RST_RDMASK = 16'hFFFF;
    localparam logic [7:0] SHS_RST_IRQMASK = 8'h00;
    localparam int SHS_CARD_STATUS_SHIFT = 16;
    localparam int SHS_MASK_OUT_OF_RANGE = 15;
    localparam int SHS_MASK_WP_VIOLATION = 10;

    // ********************************************************************
    // Bus slave states.
    // ********************************************************************
    typedef enum logic [1:0] {
        SHS_IDLE = 2'b00,
        SHS_ACK = 2'b01,
        SHS_DONE = 2'b11
    } shs_bus_state_t;

endpackage : shs_pkg

/* File: rtl/shs_status_regs.sv */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
// Operation
// - Command error flag bit 7 sets on error; only controller reset clears.
// - Data error flag bit 6 sets on error, clears only on controller reset.
// - Timeout flag bit 5 sets on command timeout, write one clears.
// - Bit 3 command engine idle: clear at start, set on good completion.
// - Bit 2 sets on card read-wait on data line 2, write one clears.
// - Bit 1 sets on card interrupt on data line 1, write one clears.
// - Card interrupt is level; bit 1 reasserts while source stays active.
// - Bit 0 controller idle: clear at start, set on good completion.
// - Every status flag is routed out as an interrupt source.
// - Mask never stops flags setting; only gates summary interrupt.
// - Slot 0 card address, 16 bits read/write, resets to zero.
// - Slot 1 card address, 16 bits read/write, resets to one.
// - Read mask bit n ignores card status bit n+16; resets all ones.
// - Mask bit 15 is out-of-range, bit 10 write-protect violation.
module shs_status_regs
    import shs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [SHS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic ctrl_soft_reset,
    input wire logic cmd_start,
    input wire logic cmd_engine_done,
    input wire logic ctrl_done,
    input wire logic cmd_error,
    input wire logic data_error,
    input wire logic cmd_timeout,
    input wire logic card_dat2_pin,
    input wire logic card_dat1_n_pin,
    input wire logic [15:0] card_status_hi,
    input wire logic card_status_valid,
    output logic read_status_error,
    output logic [7:0] status_irq_sources,
    output logic controller_irq_summary,
    output logic [15:0] card_address_slot0,
    output logic [15:0] card_address_slot1
);

    // ********************************************************************
    // Pin synchronisers for the card data lines.
    // ********************************************************************
    logic [1:0] sync_reg;
    logic [1:0] sync_next;
    logic [1:0] pin_reg;
    logic [1:0] pin_next;
    // The interrupt line is active low and is inverted ahead of the first
    // flop, so both flops reset to the idle level and no false flag
    // follows reset. Only the second flop feeds the flag logic.

    always_comb begin
        sync_next = {card_dat2_pin, ~card_dat1_n_pin};
        pin_next = sync_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync_reg <= 2'h0;
            pin_reg <= 2'h0;
        end else if (clk_en) begin
            sync_reg <= sync_next;
            pin_reg <= pin_next;
        end
    end

    // ********************************************************************
    // Avalon-MM slave: one wait cycle, then answer.
    // ********************************************************************
    shs_bus_state_t bus_reg;
    shs_bus_state_t bus_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] resp_reg;
    logic [1:0] resp_next;
    logic wait_reg;
    logic wait_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [15:0] addr0_reg;
    logic [15:0] addr0_next;
    logic [15:0] addr1_reg;
    logic [15:0] addr1_next;
    logic [15:0] rdmask_reg;
    logic [15:0] rdmask_next;
    logic [7:0] irqmask_reg;
    logic [7:0] irqmask_next;
    logic rderr_reg;
    logic rderr_next;
    logic irq_reg;
    logic irq_next;
    logic [7:0] src_reg;
    logic [7:0] src_next;
    logic [15:0] idx;
    logic hit_status;
    logic hit_addr0;
    logic hit_addr1;
    logic hit_rdmask;
    logic hit_irqmask;
    logic wr_fire;
    logic [7:0] w1c;
    logic [15:0] wmask16;

    // Read data is captured when a request is taken, so a read returns the
    // register as it stood in that cycle. A write lands at the edge that
    // completes the access, and the DONE state then gives one turnaround
    // cycle with waitrequest high.

    always_comb begin
        idx = avs_address[SHS_ADDR_W-1:2];
        hit_status = 1'b0;
        hit_addr0 = 1'b0;
        hit_addr1 = 1'b0;
        hit_rdmask = 1'b0;
        hit_irqmask = 1'b0;
        if (avs_address[1:0] != 2'h0) begin
            hit_status = 1'b0;
        end else if (idx == SHS_IDX_STATUS) begin
            hit_status = 1'b1;
        end else if (idx == SHS_IDX_ADDR0) begin
            hit_addr0 = 1'b1;
        end else if (idx == SHS_IDX_ADDR1) begin
            hit_addr1 = 1'b1;
        end else if (idx == SHS_IDX_RDMASK) begin
            hit_rdmask = 1'b1;
        end else if (idx == SHS_IDX_IRQMASK) begin
            hit_irqmask = 1'b1;
        end
        bus_next = bus_reg;
        rdata_next = rdata_reg;
        resp_next = resp_reg;
        wr_fire = 1'b0;
        case (bus_reg)
            SHS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_next = SHS_ACK;
                    resp_next = (hit_status || hit_addr0 || hit_addr1 ||
                        hit_rdmask || hit_irqmask) ? 2'h0 : 2'h2;
                    rdata_next = 32'h0000_0000;
                    if (hit_status) begin
                        rdata_next = {24'h00_0000, status_reg};
                    end else if (hit_addr0) begin
                        rdata_next = {16'h0000, addr0_reg};
                    end else if (hit_addr1) begin
                        rdata_next = {16'h0000, addr1_reg};
                    end else if (hit_rdmask) begin
                        rdata_next = {16'h0000, rdmask_reg};
                    end else if (hit_irqmask) begin
                        rdata_next = {24'h00_0000, irqmask_reg};
                    end
                end
            end
            SHS_ACK: begin
                wr_fire = avs_write;
                bus_next = SHS_DONE;
            end
            SHS_DONE: begin
                bus_next = SHS_IDLE;
            end
            default: begin
                bus_next = SHS_IDLE;
            end
        endcase
        // Waitrequest leaves a flop: it is low only while the FSM is in ACK.
        wait_next = (bus_next != SHS_ACK);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bus_reg <= SHS_IDLE;
            rdata_reg <= 32'h0000_0000;
            resp_reg <= 2'h0;
            wait_reg <= 1'b1;
        end else if (clk_en) begin
            bus_reg <= bus_next;
            rdata_reg <= rdata_next;
            resp_reg <= resp_next;
            wait_reg <= wait_next;
        end
    end

    // ********************************************************************
    // Status flags, stored registers and interrupt outputs.
    // ********************************************************************
    always_comb begin
        wmask16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        w1c = (wr_fire && hit_status && avs_byteenable[0]) ?
            avs_writedata[7:0] : 8'h00;
        status_next = status_reg;
        // Set terms follow the clears so an event in a clear cycle wins.
        status_next[SHS_BIT_TIMEOUT] = status_reg[SHS_BIT_TIMEOUT] &
            ~w1c[SHS_BIT_TIMEOUT];
        status_next[SHS_BIT_READ_WAIT] = status_reg[SHS_BIT_READ_WAIT] &
            ~w1c[SHS_BIT_READ_WAIT];
        status_next[SHS_BIT_CARD_IRQ] = status_reg[SHS_BIT_CARD_IRQ] &
            ~w1c[SHS_BIT_CARD_IRQ];
        // A done pulse wins over a start in the same cycle; a done with a command
        // error or timeout, or a controller done with a data error, leaves its idle bit clear.
        if (cmd_start) begin
            status_next[SHS_BIT_CMD_IDLE] = 1'b0;
            status_next[SHS_BIT_CTRL_IDLE] = 1'b0;
        end
        if (cmd_engine_done && !cmd_error && !cmd_timeout) begin
            status_next[SHS_BIT_CMD_IDLE] = 1'b1;
        end
        if (ctrl_done && !cmd_error && !data_error && !cmd_timeout) begin
            status_next[SHS_BIT_CTRL_IDLE] = 1'b1;
        end
        if (ctrl_soft_reset) begin
            status_next[SHS_BIT_CMD_ERR] = 1'b0;
            status_next[SHS_BIT_DATA_ERR] = 1'b0;
        end
        if (cmd_error) begin
            status_next[SHS_BIT_CMD_ERR] = 1'b1;
        end
        if (data_error) begin
            status_next[SHS_BIT_DATA_ERR] = 1'b1;
        end
        if (cmd_timeout) begin
            status_next[SHS_BIT_TIMEOUT] = 1'b1;
        end
        if (pin_reg[1]) begin
            status_next[SHS_BIT_READ_WAIT] = 1'b1;
        end
        if (pin_reg[0]) begin
            status_next[SHS_BIT_CARD_IRQ] = 1'b1;
        end
        status_next[SHS_BIT_RSVD] = 1'b0;

        addr0_next = addr0_reg;
        addr1_next = addr1_reg;
        rdmask_next = rdmask_reg;
        irqmask_next = irqmask_reg;
        if (wr_fire && hit_addr0) begin
            addr0_next = (addr0_reg & ~wmask16) |
                (avs_writedata[15:0] & wmask16);
        end
        if (wr_fire && hit_addr1) begin
            addr1_next = (addr1_reg & ~wmask16) |
                (avs_writedata[15:0] & wmask16);
        end
        if (wr_fire && hit_rdmask) begin
            rdmask_next = (rdmask_reg & ~wmask16) |
                (avs_writedata[15:0] & wmask16);
        end
        if (wr_fire && hit_irqmask && avs_byteenable[0]) begin
            irqmask_next = avs_writedata[7:0];
        end

        // Bit 15 out-of-range and bit 10 write-protect are gated by the read mask like every other bit.
        rderr_next = card_status_valid &&
            ((card_status_hi & ~rdmask_reg) != 16'h0000);
        // The interrupt mask gates only the summary; the flags and their copies to
        // the interrupt controller are never held back by them.
        src_next = status_reg;
        irq_next = (status_reg & irqmask_reg) != 8'h00;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_reg <= SHS_RST_STATUS;
            addr0_reg <= SHS_RST_ADDR0;
            addr1_reg <= SHS_RST_ADDR1;
            rdmask_reg <= SHS_RST_RDMASK;
            irqmask_reg <= SHS_RST_IRQMASK;
            rderr_reg <= 1'b0;
            irq_reg <= 1'b0;
            src_reg <= 8'h00;
        end else if (clk_en) begin
            status_reg <= status_next;
            addr0_reg <= addr0_next;
            addr1_reg <= addr1_next;
            rdmask_reg <= rdmask_next;
            irqmask_reg <= irqmask_next;
            rderr_reg <= rderr_next;
            irq_reg <= irq_next;
            src_reg <= src_next;
        end
    end

    always_comb begin
        avs_readdata = rdata_reg;
        avs_response = resp_reg;
        avs_waitrequest = wait_reg;
        read_status_error = rderr_reg;
        status_irq_sources = src_reg;
        controller_irq_summary = irq_reg;
        card_address_slot0 = addr0_reg;
        card_address_slot1 = addr1_reg;
    end

endmodule : shs_status_regs

/* File: verification/shs_card_model.sv */
`timescale 1ns/1ps
// ********************************************************************
// Card side: drives the data line indications and card status words.
// ********************************************************************
module shs_card_model (
    input wire logic clk,
    input wire logic irq_on,
    input wire logic wait_on,
    input wire logic send,
    input wire logic [15:0] word,
    output logic dat2 = 1'b0,
    output logic dat1_n = 1'b1,
    output logic [15:0] status_hi = 16'h0000,
    output logic status_valid = 1'b0
);
    always_ff @(posedge clk) begin
        dat1_n <= !irq_on;
        dat2 <= wait_on;
        status_valid <= send;
        status_hi <= send ? word : ~status_hi;
    end
endmodule : shs_card_model

/* File: verification/shs_status_regs_props.sv */
`timescale 1ns/1ps
// ********************************************************************
// Checks on the status block's ports.
// ********************************************************************
module shs_status_regs_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic avs_waitrequest,
    input wire logic ctrl_soft_reset,
    input wire logic cmd_start,
    input wire logic cmd_engine_done,
    input wire logic ctrl_done,
    input wire logic cmd_error,
    input wire logic data_error,
    input wire logic cmd_timeout,
    input wire logic card_dat1_n_pin,
    input wire logic card_status_valid,
    input wire logic read_status_error,
    input wire logic [7:0] status_irq_sources,
    input wire logic controller_irq_summary
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset || !clk_en);
    AST_CMD_ERR: assert property (cmd_error |->
        ##2 status_irq_sources[7])
        else $error("command error flag missing");
    AST_ERR_HOLD: assert property ($fell(status_irq_sources[7]) |->
        $past(ctrl_soft_reset, 2)) else $error("command error lost");
    AST_TIMEOUT: assert property (cmd_timeout |->
        ##2 status_irq_sources[5])
        else $error("timeout flag missing");
    AST_CMD_IDLE: assert property ($rose(status_irq_sources[3]) |->
        $past(cmd_engine_done && !cmd_error && !cmd_timeout, 2))
        else $error("command idle set without clean completion");
    AST_CTRL_IDLE: assert property ($rose(status_irq_sources[0]) |->
        $past(ctrl_done && !cmd_error && !data_error && !cmd_timeout, 2))
        else $error("controller idle set without clean completion");
    AST_START: assert property (cmd_start && !cmd_engine_done |->
        ##2 !status_irq_sources[3]) else $error("start left idle set");
    AST_CARD_IRQ: assert property (!card_dat1_n_pin [*6] |->
        status_irq_sources[1]) else $error("card interrupt not held");
    AST_SUMMARY: assert property (controller_irq_summary |->
        (|status_irq_sources)) else $error("summary without a flag");
    AST_RDERR: assert property (read_status_error |->
        $past(card_status_valid)) else $error("read error without status");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");
    cover property (cmd_error ##2 status_irq_sources[7]);
    cover property ($rose(status_irq_sources[1]));
    cover property (controller_irq_summary);
    cover property (read_status_error);
endmodule : shs_status_regs_props

bind shs_status_regs shs_status_regs_props u_props (.clk, .reset, .clk_en,
    .avs_waitrequest, .ctrl_soft_reset, .cmd_start, .cmd_engine_done,
    .ctrl_done, .cmd_error, .data_error, .cmd_timeout, .card_dat1_n_pin,
    .card_status_valid, .read_status_error, .status_irq_sources,
    .controller_irq_summary);

/* File: verification/test_sd_host_status_and_error_mask.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_sd_host_status_and_error_mask
    import shs_pkg::*;
    ;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [17:0] adr = 18'h00000;
    logic rd_r = 1'b0;
    logic wr_r = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [6:0] ev = 7'h00;
    logic irq_on = 1'b0;
    logic wait_on = 1'b0;
    logic send = 1'b0;
    logic [15:0] word = 16'h0000;
    logic dat2, dat1_n, sv, wreq, rse, sum;
    logic [15:0] sh, a0, a1;
    logic [31:0] rdt, rdata;
    logic [1:0] rsp, resp;
    logic [7:0] src;
    logic [15:0] cw [5] = '{16'hFFFF, 16'h8000, 16'h8000, 16'h0400, 16'h7BFF};
    logic [4:0] ce = 5'h0C;
    int miscompares = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    shs_card_model u_card (.clk(clk), .irq_on(irq_on), .wait_on(wait_on),
        .send(send), .word(word), .dat2(dat2), .dat1_n(dat1_n),
        .status_hi(sh), .status_valid(sv));
    shs_status_regs u_dut (.clk(clk), .reset(reset), .clk_en(1'b1),
        .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdt),
        .avs_waitrequest(wreq), .avs_response(rsp), .ctrl_soft_reset(ev[6]),
        .cmd_start(ev[5]), .cmd_engine_done(ev[4]), .ctrl_done(ev[3]),
        .cmd_error(ev[2]), .data_error(ev[1]), .cmd_timeout(ev[0]),
        .card_dat2_pin(dat2), .card_dat1_n_pin(dat1_n), .card_status_hi(sh),
        .card_status_valid(sv), .read_status_error(rse),
        .status_irq_sources(src), .controller_irq_summary(sum),
        .card_address_slot0(a0), .card_address_slot1(a1));
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic bus(input logic w, input logic [15:0] i,
        input logic [31:0] d);
        int n;
        n = 0;
        adr <= {i, 2'b00};
        wr_r <= w;
        rd_r <= !w;
        wd <= d;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            n++;
            if (n > 20) begin
                miscompares++;
                final_report();
            end
            @(posedge clk);
        end
        rdata = rdt;
        resp = rsp;
        wr_r <= 1'b0;
        rd_r <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rchk(input logic [15:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h00000000);
        `CHK(rdata, e)
        `CHK(resp, 2'b00)
    endtask : rchk
    task automatic pulse(input logic [6:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 7'h00;
        @(posedge clk);
    endtask : pulse
    task automatic csend(input logic [15:0] w);
        word <= w;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : csend
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rchk(SHS_IDX_STATUS, 32'h00000000);
        rchk(SHS_IDX_ADDR0, 32'h00000000);
        rchk(SHS_IDX_ADDR1, 32'h00000001);
        rchk(SHS_IDX_RDMASK, 32'h0000FFFF);
        bus(1'b1, SHS_IDX_ADDR0, 32'h0000A5C3);
        bus(1'b1, SHS_IDX_ADDR1, 32'h00003C5A);
        rchk(SHS_IDX_ADDR0, 32'h0000A5C3);
        rchk(SHS_IDX_ADDR1, 32'h00003C5A);
        `CHK(a0, 16'hA5C3)
        `CHK(a1, 16'h3C5A)
        bus(1'b1, 16'h1805, 32'h0000FFFF);
        `CHK(resp, 2'b10)
        $display("test registers done");
        pulse(7'h06);
        bus(1'b1, SHS_IDX_STATUS, 32'h000000FF);
        rchk(SHS_IDX_STATUS, 32'h000000C0);
        pulse(7'h40);
        pulse(7'h01);
        rchk(SHS_IDX_STATUS, 32'h00000020);
        bus(1'b1, SHS_IDX_STATUS, 32'h00000020);
        rchk(SHS_IDX_STATUS, 32'h00000000);
        pulse(7'h18);
        rchk(SHS_IDX_STATUS, 32'h00000009);
        pulse(7'h20);
        pulse(7'h1C);
        rchk(SHS_IDX_STATUS, 32'h00000080);
        pulse(7'h40);
        $display("test flags done");
        wait_on <= 1'b1;
        repeat (8) @(posedge clk);
        wait_on <= 1'b0;
        irq_on <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b1, SHS_IDX_STATUS, 32'h00000002);
        rchk(SHS_IDX_STATUS, 32'h00000006);
        irq_on <= 1'b0;
        repeat (6) @(posedge clk);
        bus(1'b1, SHS_IDX_STATUS, 32'h00000006);
        rchk(SHS_IDX_STATUS, 32'h00000000);
        $display("test card lines done");
        pulse(7'h01);
        repeat (2) @(posedge clk);
        `CHK(src, 8'h20)
        `CHK(sum, 1'b0)
        bus(1'b1, SHS_IDX_IRQMASK, 32'h00000020);
        repeat (2) @(posedge clk);
        `CHK(sum, 1'b1)
        bus(1'b1, SHS_IDX_STATUS, 32'h00000020);
        repeat (2) @(posedge clk);
        `CHK(sum, 1'b0)
        irq_on <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(src, 8'h02)
        `CHK(sum, 1'b0)
        irq_on <= 1'b0;
        repeat (6) @(posedge clk);
        bus(1'b1, SHS_IDX_STATUS, 32'h00000002);
        $display("test summary done");
        pulse(7'h02);
        for (int k = 0; k < 5; k++) begin
            if (k == 2) begin
                bus(1'b1, SHS_IDX_RDMASK, 32'h00007BFF);
            end
            csend(cw[k]);
            `CHK(rse, ce[k])
        end
        $display("test read mask done");
        final_report();
    end
endmodule : test_sd_host_status_and_error_mask
